// ===== dv/sbm_eeprom_model.sv
// Behavioural byte-addressed EEPROM slave on the two-wire bus.
// Assumes the bench resolves both wires with pullups.
`timescale 1ns/1ns
module sbm_eeprom_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // Resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // High pulls SDA low; never drives high
  output logic      sda_oe
);
  logic [7:0] mem [256] = '{default: 8'hFF}; // Storage, blank reads FFh
  logic [7:0] sh  = 8'h00;  // Received bits
  logic [7:0] tx  = 8'hFF;  // Byte being sent
  logic [7:0] ptr = 8'h00;  // Word address, auto-increments
  logic       act = 1'b0;   // Inside a frame
  logic       ok  = 1'b0;   // Addressed and still talking
  logic       rd  = 1'b0;   // Direction of this frame
  int         ph  = 0;      // 0 addr, 1 index, 2 write data, 3 read data
  int         n   = 0;      // Bit position in the byte
  initial sda_oe = 1'b0;

  // Start or repeated start; only the master makes these
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    ph = 0;
    n = -1;
    sda_oe = 1'b0;
  end

  // Stop ends the frame
  always @(posedge sda) if (scl) act = 1'b0;

  // Sample while SCL is high; a master NACK ends the read
  always @(posedge scl) if (act) begin
    if (n < 8) sh = {sh[6:0], sda};
    else if (ph == 3 && sda) ok = 1'b0;
  end

  // Every SDA change happens while SCL is low
  always @(negedge scl) if (act) begin
    if (n == 7) begin
      // Byte boundary, ninth slot is the acknowledge
      n = 8;
      if (ph == 0) begin
        ok = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (ph == 1 && ok) begin
        ptr = sh;
      end else if (ph == 2 && ok) begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
      sda_oe = ok && ph != 3;
    end else begin
      if (n == 8) begin
        n = 0;
        if (ph == 0) ph = rd ? 3 : 1;
        else if (ph == 1) ph = 2;
        if (ph == 3) begin
          tx = mem[ptr];
          ptr = ptr + 8'h01;
        end
      end else begin
        n = n + 1;
      end
      sda_oe = ok && ph == 3 && !tx[7-n];
    end
  end
endmodule

// ===== dv/sbm_serial_bus_master_assertions.sv
// Checker for the serial bus master: pin, status and timing relations.
// Sees only the top module ports; bound into every instance below.
`timescale 1ns/1ns
module sbm_checker
  import sbm_pkg::*;
#(
  parameter int QTR = 4
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  // Strap and pins
  input wire logic        latch_strap,
  input wire logic        multifunction_pin_four_i,
  input wire logic        multifunction_pin_four_o,
  input wire logic        multifunction_pin_four_oe,
  input wire logic        multifunction_pin_one_i,
  input wire logic        multifunction_pin_one_o,
  input wire logic        multifunction_pin_one_oe,
  // Software side
  input wire logic        sw_start,
  input wire sbm_req_s    sw_req,
  input wire logic        status_wr,
  input wire logic [7:0]  status_wdata,
  input wire sbm_status_s status,
  input wire logic [7:0]  rd_data,
  // Loader side
  input wire logic        load_busy,
  input wire logic        load_valid,
  input wire sbm_load_s   load_word
);
  // Bounds in cycles; sized for the short quarter used in simulation
  localparam int BIT_MAX = 4 * QTR + 2;
  localparam int TXN_MAX = 42 * 4 * QTR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic [15:0] rel_cnt_r; // Cycles SCL has been left released
  logic        rd_cap_r;  // Direction of the last request made while idle, enabled or not
  logic        en_seen_r; // Interface found enabled since reset

  // Count released cycles; saturates so a long idle cannot wrap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rel_cnt_r <= 16'h0000;
    end else if (multifunction_pin_four_oe) begin
      rel_cnt_r <= 16'h0000;
    end else if (rel_cnt_r != 16'hFFFF) begin
      rel_cnt_r <= rel_cnt_r + 16'h0001;
    end
  end

  // Flag and enable are judged at one edge; the flag may be cleared later
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en_seen_r <= 1'b0;
    end else if (status.bus_detected_flag) begin
      en_seen_r <= 1'b1;
    end
  end

  // Remember whether the last request made while idle was a read, even if refused
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_cap_r <= 1'b0;
    end else if (sw_start && !load_busy && !status.busy) begin
      rd_cap_r <= sw_req.rd;
    end
  end

  a_idle_released: assert property (!status.busy && !load_busy |->
    !multifunction_pin_four_oe && !multifunction_pin_one_oe) else $error("line held when idle");
  a_pins_drive_low: assert property (
    !multifunction_pin_four_o && !multifunction_pin_one_o) else $error("pin drives a high level");
  a_scl_rate: assert property ($rose(multifunction_pin_four_oe)
    && (status.busy || load_busy)
    |-> rel_cnt_r >= 16'(2 * QTR - 1)) else $error("SCL high phase too short");
  a_start_edge: assert property ($rose(multifunction_pin_one_oe)
    && !multifunction_pin_four_oe
    |-> multifunction_pin_one_oe throughout (##[1:BIT_MAX] multifunction_pin_four_oe))
    else $error("start not followed by SCL low");
  a_stop_edge: assert property ($fell(multifunction_pin_one_oe)
    && !multifunction_pin_four_oe
    |=> (!multifunction_pin_four_oe && !multifunction_pin_one_oe) [*2]) else $error("bad stop");
  a_sda_apart: assert property ($changed(multifunction_pin_one_oe)
    |-> $stable(multifunction_pin_four_oe)) else $error("SDA and SCL switch together");
  a_start_accept: assert property (sw_start && !load_busy && !status.busy
    && en_seen_r |=> status.busy) else $error("request not taken");
  a_flag_clear: assert property (status_wr && status_wdata[3] && !load_busy
    |=> !status.bus_detected_flag) else $error("flag not cleared");
  a_flag_keep: assert property (status_wr && !status_wdata[3] && status.bus_detected_flag
    |=> status.bus_detected_flag) else $error("flag lost on zero write");
  a_read_valid: assert property ($fell(status.busy)
    |-> status.rd_valid == (rd_cap_r && !status.nack_err)) else $error("read valid wrong");
  a_busy_bound: assert property ($rose(status.busy) |-> ##[1:TXN_MAX] !status.busy)
    else $error("transaction never ends");

  c_load: cover property (load_valid);
  c_read: cover property ($fell(status.busy) && status.rd_valid);
  c_nack: cover property ($rose(status.nack_err));
endmodule

bind sbm_serial_bus_master sbm_checker #(.QTR(QTR)) i_chk (
  .clk_sys, .arst_n, .latch_strap,
  .multifunction_pin_four_i, .multifunction_pin_four_o, .multifunction_pin_four_oe,
  .multifunction_pin_one_i, .multifunction_pin_one_o, .multifunction_pin_one_oe,
  .sw_start, .sw_req, .status_wr, .status_wdata, .status, .rd_data,
  .load_busy, .load_valid, .load_word
);

// ===== dv/tb_top.sv
// Self-checking bench for the serial bus master with an EEPROM slave.
// Assumes pullups on both wires; QTR shortened so a bit is 16 cycles.
`timescale 1ns/1ns
module tb_top;
  import sbm_pkg::*;
  localparam int Q = 4;                 // Quarter bit in cycles
  logic        clk_sys      = 1'b0;     // 100 MHz
  logic        arst_n       = 1'b0;     // Held low at start
  logic        latch_strap  = 1'b0;     // Low enables the interface
  logic        sw_start     = 1'b0;     // Request strobe
  sbm_req_s    sw_req       = '0;       // Request fields
  logic        status_wr    = 1'b0;     // Status write strobe
  logic [7:0]  status_wdata = 8'h00;    // Status write value
  logic        scl_oe;                  // Master pulls SCL
  logic        sda_oe;                  // Master pulls SDA
  logic        mdl_oe;                  // Slave pulls SDA
  sbm_status_s status;                  // Status byte
  logic [7:0]  rd_data;                 // Last read byte
  logic        load_busy;               // Loader running
  logic        load_valid;              // Loaded word strobe
  sbm_load_s   load_word;               // Loaded word
  sbm_load_s   loads [$];               // Every loaded word seen
  int          n_mismatch   = 0;
  int          tests_run    = 0;
  wire         scl = !scl_oe;           // Pulled up unless held
  wire         sda = !(sda_oe || mdl_oe);

  always #5 clk_sys = ~clk_sys;

  // Collect loader output in the cycle it stands
  always @(posedge clk_sys) if (load_valid === 1'b1) loads.push_back(load_word);

  sbm_serial_bus_master #(.QTR(Q)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .latch_strap(latch_strap),
    .multifunction_pin_four_i(scl), .multifunction_pin_four_o(),
    .multifunction_pin_four_oe(scl_oe), .multifunction_pin_one_i(sda),
    .multifunction_pin_one_o(), .multifunction_pin_one_oe(sda_oe),
    .sw_start(sw_start), .sw_req(sw_req), .status_wr(status_wr),
    .status_wdata(status_wdata), .status(status), .rd_data(rd_data),
    .load_busy(load_busy), .load_valid(load_valid), .load_word(load_word)
  );

  sbm_eeprom_model i_mdl (.scl(scl), .sda(sda), .sda_oe(mdl_oe));

  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always change 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait until neither loader nor transfer is running
  task automatic wait_idle();
    int i;
    i = 0;
    while ((load_busy !== 1'b0 || status.busy !== 1'b0) && i < 30000) begin
      tick(1);
      i++;
    end
    if (i == 30000) begin
      n_mismatch++;
      $display("[FAIL] %0t wait for idle ran out", $time);
      final_report();
    end
  endtask

  task automatic do_reset(input logic strap);
    arst_n = 1'b0;
    latch_strap = strap;
    tick(3);
    arst_n = 1'b1;
    tick(1);
    wait_idle();
  endtask

  // One software byte transfer, strobe held for one edge
  task automatic xfer(input logic [6:0] a, input logic r,
                      input logic [7:0] i, input logic [7:0] d);
    sw_req = '{dev_addr: a, rd: r, index: i, wdata: d};
    sw_start = 1'b1;
    tick(1);
    sw_start = 1'b0;
    tick(1);
    wait_idle();
  endtask

  task automatic wr_status(input logic [7:0] v);
    status_wdata = v;
    status_wr = 1'b1;
    tick(1);
    status_wr = 1'b0;
    tick(1);
  endtask

  initial begin
    #1;
    // Two records then the end-of-list marker at 8-byte stride
    i_mdl.mem[0] = 8'h01;
    {i_mdl.mem[1], i_mdl.mem[2], i_mdl.mem[3], i_mdl.mem[4]} = 32'hDEADBEEF;
    i_mdl.mem[8] = 8'h04;
    {i_mdl.mem[9], i_mdl.mem[10], i_mdl.mem[11], i_mdl.mem[12]} = 32'h11223344;
    do_reset(1'b0);
    check(40'(loads.size()), 40'h2);
    check(loads[0], {8'h01, 32'hDEADBEEF});
    check(loads[1], {8'h04, 32'h11223344});
    check(status, 8'h08);
    wr_status(8'hF7);
    check(status.bus_detected_flag, 1'b1);
    wr_status(8'h08);
    check(status.bus_detected_flag, 1'b0);
    xfer(7'h50, RW_WRITE, 8'h30, 8'hA5);
    check(i_mdl.mem[8'h30], 8'hA5);
    check(status, 8'h00);
    xfer(7'h50, RW_READ, 8'h30, 8'h00);
    check(rd_data, 8'hA5);
    check(status, 8'h40);
    xfer(7'h50, RW_READ, 8'h09, 8'h00);
    check(rd_data, 8'h11);
    xfer(7'h22, RW_WRITE, 8'h30, 8'h5A);
    check(status, 8'h02);
    xfer(7'h22, RW_READ, 8'h30, 8'h00);
    check(status, 8'h02);
    // Unknown reference ends the load with an error
    i_mdl.mem[0] = 8'h07;
    loads.delete();
    do_reset(1'b0);
    check(status, 8'h0C);
    check(40'(loads.size()), 40'h0);
    // Strap high: interface stays off and refuses requests
    do_reset(1'b1);
    xfer(7'h50, RW_WRITE, 8'h31, 8'h77);
    check(status, 8'h00);
    check(i_mdl.mem[8'h31], 8'hFF);
    check({scl_oe, sda_oe}, 2'b00);
    final_report();
  end
endmodule

// ===== hw/sbm_pkg.sv
// Shared constants and types for the serial bus master.
// Assumes a 100 MHz system clock and open-drain pins with external pullups.
package sbm_pkg;
  // Timing: a quarter of the shortest legal SCL period, rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles the synchronised strap and lines settle before sampling
  localparam int SETTLE_CYC    = 8;

  // Quarter phases of one SCL bit
  localparam logic [1:0] Q_DRIVE  = 2'h0;
  localparam logic [1:0] Q_RISE   = 2'h1;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_FALL   = 2'h3;
  // Bit index of the acknowledge slot after eight data bits
  localparam logic [3:0] ACK_BIT  = 4'h8;
  localparam logic       RW_WRITE = 1'h0;
  localparam logic       RW_READ  = 1'h1;

  // Initialisation load format
  localparam logic [6:0] EEPROM_ADDR = 7'h50;
  localparam logic [7:0] END_OF_LIST = 8'hFF;
  localparam logic [7:0] REF_FIRST   = 8'h01;
  localparam logic [7:0] REF_LAST    = 8'h04;
  localparam logic [7:0] DATA_OFS    = 8'h01;
  localparam logic [7:0] REC_STRIDE  = 8'h08;
  localparam logic [2:0] DWORD_BYTES = 3'h4;
  localparam logic [2:0] ONE_BYTE    = 3'h1;

  // Line engine states
  typedef enum logic [2:0] {
    B_IDLE  = 3'b000,
    B_START = 3'b001,
    B_TX    = 3'b010,
    B_RX    = 3'b011,
    B_STOP  = 3'b100
  } sbm_bus_e;

  // Byte currently on the wire
  typedef enum logic [1:0] {
    P_ADDRW = 2'b00,
    P_INDEX = 2'b01,
    P_DATA  = 2'b10,
    P_ADDRR = 2'b11
  } sbm_phase_e;

  // Initialisation loader states
  typedef enum logic [1:0] {
    I_WAIT = 2'b00,
    I_REF  = 2'b01,
    I_DATA = 2'b10,
    I_DONE = 2'b11
  } sbm_init_e;

  // Software request: slave address, direction, word address, write data
  typedef struct packed {
    logic [6:0] dev_addr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } sbm_req_s;

  // Control/status byte; bus_detected_flag sits at bit 3
  typedef struct packed {
    logic       busy;
    logic       rd_valid;
    logic [1:0] rsvd_hi;
    logic       bus_detected_flag;
    logic       rom_err;
    logic       nack_err;
    logic       rsvd_lo;
  } sbm_status_s;

  // One loaded register: offset reference and its doubleword
  typedef struct packed {
    logic [7:0]  ref_ofs;
    logic [31:0] data;
  } sbm_load_s;
endpackage

// ===== hw/sbm_serial_bus_master.sv
// Standard-mode two-wire bus master with strap detection and EEPROM loader.
// Assumes pullups on both lines and that software waits for busy to drop.
`timescale 1ns/1ns

module sbm_serial_bus_master
  import sbm_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Strap and open-drain pins
  input  wire logic        latch_strap,
  input  wire logic        multifunction_pin_four_i,
  output logic             multifunction_pin_four_o,
  output logic             multifunction_pin_four_oe,
  input  wire logic        multifunction_pin_one_i,
  output logic             multifunction_pin_one_o,
  output logic             multifunction_pin_one_oe,
  // Software access
  input  wire logic        sw_start,
  input  wire sbm_req_s    sw_req,
  input  wire logic        status_wr,
  input  wire logic [7:0]  status_wdata,
  output sbm_status_s      status,
  output logic [7:0]       rd_data,
  // Initialisation load results
  output logic             load_busy,
  output logic             load_valid,
  output sbm_load_s        load_word
);

  localparam int QW = $clog2(QTR);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  // True for an offset reference the loader knows
  function automatic logic valid_ref(input logic [7:0] b);
    valid_ref = (b >= REF_FIRST) && (b <= REF_LAST);
  endfunction

  // Input synchronisers: {strap, data, clock}
  logic [2:0] raw_in;
  logic [2:0] s1_r;                   // First stage, read only by s2_r
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;                 // Accepted level once s2 and s3 agree
  logic       scl_f;
  logic       sda_f;
  logic       latch_f;

  assign raw_in  = {latch_strap, multifunction_pin_one_i, multifunction_pin_four_i};
  assign scl_f   = filt_r[0];
  assign sda_f   = filt_r[1];
  assign latch_f = filt_r[2];

  // Three synchroniser flops and a filter flop per input; idle level high matches released lines
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          s1_r[g]   <= 1'b1;
          s2_r[g]   <= 1'b1;
          s3_r[g]   <= 1'b1;
          filt_r[g] <= 1'b1;
        end else begin
          s1_r[g] <= raw_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          // Glitch of one cycle never reaches the filter output
          if (s2_r[g] == s3_r[g]) begin
            filt_r[g] <= s2_r[g];
          end
        end
      end
    end
  endgenerate

  // Strap detection state
  logic [SW-1:0] settle_r;            // Cycles since reset release
  logic          sampled_r;           // Strap has been judged
  logic          en_r;                // Interface enabled
  logic          det_r;               // Detected flag
  logic          det_set;
  sbm_status_s   wr_bits;             // Written status byte viewed as fields

  assign wr_bits = sbm_status_s'(status_wdata);
  assign det_set = !sampled_r && (settle_r == SW'(SETTLE_CYC))
                   && !latch_f && scl_f && sda_f;

  // Judge the strap once, after the synchronisers have settled
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      settle_r  <= '0;
      sampled_r <= 1'b0;
      en_r      <= 1'b0;
    end else if (!sampled_r) begin
      if (settle_r == SW'(SETTLE_CYC)) begin
        sampled_r <= 1'b1;
        en_r      <= det_set;
      end else begin
        settle_r <= settle_r + SW'(1);
      end
    end
  end

  // Detected flag: set wins over a simultaneous write-one clear
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      det_r <= 1'b0;
    end else if (det_set) begin
      det_r <= 1'b1;
    end else if (status_wr && wr_bits.bus_detected_flag) begin
      det_r <= 1'b0;
    end
  end

  // Transaction descriptor, owned by the sequencer
  logic [6:0] d_dev_r;
  logic       d_rd_r;
  logic [7:0] d_idx_r;
  logic [7:0] d_dat_r;
  logic [2:0] d_nrd_r;                // Bytes to receive
  logic       kick_r;                 // One-cycle start to the engine

  // Line engine state
  sbm_bus_e   st_r;
  sbm_phase_e ph_r;
  logic [1:0] qph_r;
  logic [3:0] bitn_r;
  logic [7:0] shf_r;
  logic [2:0] rcnt_r;
  logic       ackbad_r;               // Sampled acknowledge slot was high
  logic       nack_r;                 // Transaction saw a missing ack
  logic       done_r;                 // One-cycle end of transaction
  logic [31:0] rxw_r;                 // Received bytes, first one highest
  logic       scl_oe_r;
  logic       sda_oe_r;
  logic [QW-1:0] qcnt_r;
  logic       tick;

  assign tick = (qcnt_r == QW'(QTR - 1));

  // Quarter-bit timer; held at zero between transfers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qcnt_r <= '0;
    end else if (st_r == B_IDLE || tick) begin
      qcnt_r <= '0;
    end else begin
      qcnt_r <= qcnt_r + QW'(1);
    end
  end

  // Line engine: start, bytes with acknowledge, repeated start, stop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r     <= B_IDLE;
      ph_r     <= P_ADDRW;
      qph_r    <= Q_DRIVE;
      bitn_r   <= '0;
      shf_r    <= '0;
      rcnt_r   <= '0;
      ackbad_r <= 1'b0;
      nack_r   <= 1'b0;
      done_r   <= 1'b0;
      rxw_r    <= '0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (st_r == B_IDLE) begin
        // Lines stay released while idle, so SCL stops
        scl_oe_r <= 1'b0;
        sda_oe_r <= 1'b0;
        if (kick_r) begin
          st_r   <= B_START;
          ph_r   <= P_ADDRW;
          qph_r  <= Q_DRIVE;
          nack_r <= 1'b0;
          rcnt_r <= d_nrd_r;
        end
      end else if (tick) begin
        qph_r <= qph_r + 2'h1;
        unique case (st_r)
          B_START: begin
            unique case (qph_r)
              Q_DRIVE:  sda_oe_r <= 1'b0;   // Release data first; clock high from idle, low on a repeated start
              Q_RISE:   scl_oe_r <= 1'b0;
              Q_SAMPLE: sda_oe_r <= 1'b1;
              Q_FALL: begin
                scl_oe_r <= 1'b1;
                st_r     <= B_TX;
                bitn_r   <= '0;
                shf_r    <= {d_dev_r, (ph_r == P_ADDRR) ? RW_READ : RW_WRITE};
              end
            endcase
          end
          B_TX: begin
            unique case (qph_r)
              // Data moves only in the low quarter
              Q_DRIVE:  sda_oe_r <= (bitn_r == ACK_BIT) ? 1'b0 : !shf_r[7];
              Q_RISE:   scl_oe_r <= 1'b0;
              Q_SAMPLE: ackbad_r <= sda_f;
              Q_FALL: begin
                scl_oe_r <= 1'b1;
                if (bitn_r != ACK_BIT) begin
                  shf_r  <= {shf_r[6:0], 1'b0};
                  bitn_r <= bitn_r + 4'h1;
                end else if (ackbad_r) begin
                  nack_r <= 1'b1;
                  st_r   <= B_STOP;
                end else begin
                  bitn_r <= '0;
                  unique case (ph_r)
                    P_ADDRW: begin
                      ph_r  <= P_INDEX;
                      shf_r <= d_idx_r;
                    end
                    P_INDEX: begin
                      if (d_rd_r) begin
                        ph_r <= P_ADDRR;
                        st_r <= B_START;
                      end else begin
                        ph_r  <= P_DATA;
                        shf_r <= d_dat_r;
                      end
                    end
                    P_DATA:  st_r <= B_STOP;
                    P_ADDRR: st_r <= B_RX;
                  endcase
                end
              end
            endcase
          end
          B_RX: begin
            unique case (qph_r)
              // Released for data; ack driven except after the last byte
              Q_DRIVE:  sda_oe_r <= (bitn_r == ACK_BIT) && (rcnt_r != ONE_BYTE);
              Q_RISE:   scl_oe_r <= 1'b0;
              Q_SAMPLE: begin
                if (bitn_r != ACK_BIT) begin
                  shf_r <= {shf_r[6:0], sda_f};
                end
              end
              Q_FALL: begin
                scl_oe_r <= 1'b1;
                if (bitn_r != ACK_BIT) begin
                  bitn_r <= bitn_r + 4'h1;
                end else begin
                  bitn_r <= '0;
                  rxw_r  <= {rxw_r[23:0], shf_r};
                  rcnt_r <= rcnt_r - 3'h1;
                  if (rcnt_r == ONE_BYTE) begin
                    st_r <= B_STOP;
                  end
                end
              end
            endcase
          end
          B_STOP: begin
            unique case (qph_r)
              Q_DRIVE:  sda_oe_r <= 1'b1;
              Q_RISE:   scl_oe_r <= 1'b0;
              Q_SAMPLE: sda_oe_r <= 1'b0;
              Q_FALL: begin
                st_r   <= B_IDLE;
                done_r <= 1'b1;
              end
            endcase
          end
          default: st_r <= B_IDLE;
        endcase
      end
    end
  end

  // Sequencer and status
  sbm_init_e  ini_r;
  logic [7:0] ptr_r;                  // EEPROM word address of next record
  logic [7:0] ref_r;
  logic       busy_r;
  logic       rdv_r;
  logic       err_r;
  logic       rom_r;
  logic [7:0] rd_data_r;
  logic       load_valid_r;
  sbm_load_s  load_word_r;
  logic       sw_take;
  logic       rom_fail;
  logic [7:0] rxb;

  assign rxb     = rxw_r[7:0];
  // Software may only issue single-byte work once the loader is finished
  assign sw_take = sw_start && en_r && (ini_r == I_DONE) && !busy_r;
  assign rom_fail = done_r && (nack_r || ((ini_r == I_REF) && rxb != END_OF_LIST
                    && !valid_ref(rxb))) && (ini_r == I_REF || ini_r == I_DATA);

  // Loader walks records at the EEPROM, then hands the bus to software
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ini_r        <= I_WAIT;
      ptr_r        <= '0;
      ref_r        <= '0;
      d_dev_r      <= '0;
      d_rd_r       <= 1'b0;
      d_idx_r      <= '0;
      d_dat_r      <= '0;
      d_nrd_r      <= '0;
      kick_r       <= 1'b0;
      load_valid_r <= 1'b0;
      load_word_r  <= '0;
    end else begin
      kick_r       <= 1'b0;
      load_valid_r <= 1'b0;
      unique case (ini_r)
        I_WAIT: begin
          if (sampled_r) begin
            if (en_r) begin
              ini_r   <= I_REF;
              d_dev_r <= EEPROM_ADDR;
              d_rd_r  <= RW_READ;
              d_idx_r <= ptr_r;
              d_nrd_r <= ONE_BYTE;
              kick_r  <= 1'b1;
            end else begin
              ini_r <= I_DONE;
            end
          end
        end
        I_REF: begin
          if (rom_fail || (done_r && rxb == END_OF_LIST)) begin
            ini_r <= I_DONE;
          end else if (done_r) begin
            ref_r   <= rxb;
            d_idx_r <= ptr_r + DATA_OFS;
            d_nrd_r <= DWORD_BYTES;
            kick_r  <= 1'b1;
            ini_r   <= I_DATA;
          end
        end
        I_DATA: begin
          if (rom_fail) begin
            ini_r <= I_DONE;
          end else if (done_r) begin
            load_valid_r <= 1'b1;
            load_word_r  <= '{ref_ofs: ref_r, data: rxw_r};
            ptr_r        <= ptr_r + REC_STRIDE;
            d_idx_r      <= ptr_r + REC_STRIDE;
            d_nrd_r      <= ONE_BYTE;
            kick_r       <= 1'b1;
            ini_r        <= I_REF;
          end
        end
        I_DONE: begin
          if (sw_take) begin
            d_dev_r <= sw_req.dev_addr;
            d_rd_r  <= sw_req.rd;
            d_idx_r <= sw_req.index;
            d_dat_r <= sw_req.wdata;
            d_nrd_r <= ONE_BYTE;
            kick_r  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Software status: read valid and NACK error cleared by the next start, set by the engine; ROM error held until reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_r    <= 1'b0;
      rdv_r     <= 1'b0;
      err_r     <= 1'b0;
      rom_r     <= 1'b0;
      rd_data_r <= '0;
    end else begin
      if (rom_fail) begin
        rom_r <= 1'b1;
      end
      if (sw_take) begin
        busy_r <= 1'b1;
        rdv_r  <= 1'b0;
        err_r  <= 1'b0;
      end else if (busy_r && done_r) begin
        busy_r <= 1'b0;
        err_r  <= nack_r;
        rdv_r  <= d_rd_r && !nack_r;
        if (d_rd_r && !nack_r) begin
          rd_data_r <= rxb;
        end
      end
    end
  end

  // Pins go live only when the strap selected the serial interface
  assign multifunction_pin_four_o  = 1'b0;
  assign multifunction_pin_one_o   = 1'b0;
  assign multifunction_pin_four_oe = en_r && scl_oe_r;
  assign multifunction_pin_one_oe  = en_r && sda_oe_r;

  assign status = '{busy: busy_r, rd_valid: rdv_r, rsvd_hi: 2'h0,
                    bus_detected_flag: det_r, rom_err: rom_r,
                    nack_err: err_r, rsvd_lo: 1'b0};
  assign rd_data    = rd_data_r;
  assign load_busy  = (ini_r != I_DONE);
  assign load_valid = load_valid_r;
  assign load_word  = load_word_r;

endmodule
